/* logic/ext_bus_defines.svh */
// Timing counts and field widths for the external bus grant and read block.
// Assumes a 20 MHz system clock; the processor cycle is a divided enable.
`ifndef EXT_BUS_DEFINES_SVH
`define EXT_BUS_DEFINES_SVH
`define CLK_PERIOD_NS      50
`define PROC_CYCLE_CLKS    4
`define PHASE_W            2
`define PHASE_FALL         2'h2
`define REQ_MIN_PULSE_NS   10
`define WAIT_W             3
`define ADDR_W             14
`define DATA_W             24
`define SEL_W              3
`define SEL_PROG           3'h1
`define SEL_DATA           3'h2
`define SEL_BOOT           3'h4
`define SEL_NONE           3'h0
`endif

/* logic/ext_bus_pkg.sv */
// Types for the external bus grant and read block.
// Assumes ext_bus_defines.svh is on the include path.
package ext_bus_pkg;
	typedef enum logic [1:0] {MEM_PROG, MEM_DATA, MEM_BOOT} mem_space_t;
	typedef enum {ST_IDLE, ST_ADDR, ST_STROBE, ST_HOLD} rd_state_t;
	typedef enum {GR_OWN, GR_RELEASE, GR_GRANTED} grant_state_t;
endpackage : ext_bus_pkg

/* logic/ext_bus_ctl_if.sv */
// Carrier between the grant arbiter and the read sequencer.
// Assumes both ends share the one system clock.
`timescale 1ns/1ps
`default_nettype none
interface ext_bus_ctl_if;
	logic bus_released;
	logic rd_idle;
	modport arb (output bus_released, input rd_idle);
	modport seq (input bus_released, output rd_idle);
endinterface : ext_bus_ctl_if
`default_nettype wire

/* logic/ext_bus_read_seq.sv */
// Read cycle sequencer: address, selects, stretched read strobe.
// Assumes the processor-cycle enable and phase come from the top.
`include "ext_bus_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ext_bus_read_seq
	import ext_bus_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic                   cyc_en,
	input  wire logic                   fall_en,
	ext_bus_ctl_if.seq                  ctl,
	input  wire logic                   rd_req,
	input  wire ext_bus_pkg::mem_space_t rd_space,
	input  wire logic [`ADDR_W-1:0]     rd_addr,
	input  wire logic [`WAIT_W-1:0]     rd_waits,
	input  wire logic [`DATA_W-1:0]     mem_data_in,
	output logic                        rd_busy,
	output logic                        rd_done,
	output logic [`DATA_W-1:0]          rd_data,
	output logic [`ADDR_W-1:0]          mem_addr,
	output logic [`SEL_W-1:0]           sel_q_out,
	output logic                        rd_strobe
);
	rd_state_t                state_q;
	logic [`WAIT_W-1:0]       wait_q;
	logic [`SEL_W-1:0]        sel_q;
	logic                     done_q;
	logic [`DATA_W-1:0]       data_q;
	logic [`ADDR_W-1:0]       addr_q;
	logic                     strobe_q;

	function automatic logic [`SEL_W-1:0] sel_of(input mem_space_t s);
		case (s)
			MEM_PROG: sel_of = `SEL_PROG;
			MEM_DATA: sel_of = `SEL_DATA;
			MEM_BOOT: sel_of = `SEL_BOOT;
			default:  sel_of = `SEL_NONE;
		endcase
	endfunction : sel_of

	wire start = rd_req && !ctl.bus_released && state_q == ST_IDLE;

	// Address and selects change only in idle, after the strobe ended
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q  <= ST_IDLE;
			wait_q   <= '0;
			sel_q    <= `SEL_NONE;
			addr_q   <= '0;
			strobe_q <= 1'b0;
			done_q   <= 1'b0;
			data_q   <= '0;
		end
		else
		begin
			done_q <= 1'b0;
			case (state_q)
				ST_IDLE:
					if (start && cyc_en)
					begin
						sel_q  <= sel_of(rd_space);
						addr_q <= rd_addr;
						wait_q <= rd_waits;
						state_q <= ST_ADDR;
					end
					else if (!rd_req)
						sel_q <= `SEL_NONE;
				ST_ADDR:
					if (fall_en)
					begin
						strobe_q <= 1'b1;
						state_q  <= ST_STROBE;
					end
				ST_STROBE:
					if (fall_en)
					begin
						if (wait_q == '0)
						begin
							// Sample data as the strobe ends
							data_q   <= mem_data_in;
							strobe_q <= 1'b0;
							done_q   <= 1'b1;
							state_q  <= ST_HOLD;
						end
						else
							wait_q <= wait_q - 1'b1;
					end
				ST_HOLD:
					if (cyc_en)
						state_q <= ST_IDLE;
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	assign ctl.rd_idle = state_q == ST_IDLE && !start;
	assign rd_busy   = state_q != ST_IDLE;
	assign rd_done   = done_q;
	assign rd_data   = data_q;
	assign mem_addr  = addr_q;
	assign sel_q_out = sel_q;
	assign rd_strobe = strobe_q;
endmodule : ext_bus_read_seq
`default_nettype wire

/* logic/ext_bus_grant_and_read.sv */
// Top: bus request/grant arbiter plus external memory read cycles.
// Assumes a free-running 20 MHz clk; the request pin is asynchronous.
`include "ext_bus_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ext_bus_grant_and_read
	import ext_bus_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire logic                    ext_bus_request_n,
	output logic                         bus_grant_out_n,
	output logic                         processor_clock_out,
	input  wire logic                    rd_req,
	input  wire ext_bus_pkg::mem_space_t rd_space,
	input  wire logic [`ADDR_W-1:0]      rd_addr,
	input  wire logic [`WAIT_W-1:0]      rd_waits,
	output logic                         rd_busy,
	output logic                         rd_done,
	output logic [`DATA_W-1:0]           rd_data,
	input  wire logic [`DATA_W-1:0]      mem_data_in,
	output logic [`ADDR_W-1:0]           mem_addr_out,
	output logic                         mem_addr_oe,
	output logic                         prog_mem_select_n,
	output logic                         data_mem_select_n,
	output logic                         boot_mem_select_n,
	output logic                         read_strobe_n,
	output logic                         ctl_oe
);
	logic [`PHASE_W-1:0] phase_q;
	logic                req_s1_q;
	logic                req_s2_q;
	logic                accepted_q;
	logic                released_q;
	logic                grant_q;
	grant_state_t        gst_q;
	logic [`SEL_W-1:0]   sel;
	logic                strobe;
	logic                ck_out_q;

	ext_bus_ctl_if ctl ();

	// Processor cycle is four system clocks; clock-out high in first half
	wire cyc_en  = phase_q == '0;
	wire fall_en = phase_q == `PHASE_FALL;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			phase_q  <= '0;
			ck_out_q <= 1'b0;
		end
		else
		begin
			phase_q  <= phase_q + 1'b1;
			ck_out_q <= phase_q + 1'b1 < `PHASE_FALL;
		end
	end

	// Two flops before any logic sees the pin
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
		end
		else
		begin
			req_s1_q <= !ext_bus_request_n;
			req_s2_q <= req_s1_q;
		end
	end

	// Pulses shorter than a processor cycle may be missed; requester holds
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			accepted_q <= 1'b0;
			gst_q      <= GR_OWN;
			released_q <= 1'b0;
			grant_q    <= 1'b0;
		end
		else if (cyc_en)
		begin
			accepted_q <= req_s2_q;
			case (gst_q)
				// Release on the recognising edge so the grant lands one
				// processor cycle later; an idle read that starts now wins
				GR_OWN:
					if (req_s2_q && ctl.rd_idle)
					begin
						released_q <= 1'b1;
						gst_q      <= GR_RELEASE;
					end
				GR_RELEASE:
				begin
					grant_q <= 1'b1;
					gst_q   <= GR_GRANTED;
				end
				GR_GRANTED:
					if (!accepted_q)
					begin
						grant_q <= 1'b0;
						released_q <= 1'b0;
						gst_q   <= GR_OWN;
					end
				default: gst_q <= GR_OWN;
			endcase
		end
	end

	assign ctl.bus_released = released_q || accepted_q;

	ext_bus_read_seq u_seq (
		.clk         (clk),
		.rst_n       (rst_n),
		.cyc_en      (cyc_en),
		.fall_en     (fall_en),
		.ctl         (ctl),
		.rd_req      (rd_req),
		.rd_space    (rd_space),
		.rd_addr     (rd_addr),
		.rd_waits    (rd_waits),
		.mem_data_in (mem_data_in),
		.rd_busy     (rd_busy),
		.rd_done     (rd_done),
		.rd_data     (rd_data),
		.mem_addr    (mem_addr_out),
		.sel_q_out   (sel),
		.rd_strobe   (strobe)
	);

	assign processor_clock_out = ck_out_q;
	assign bus_grant_out_n     = !grant_q;
	assign ctl_oe              = !released_q;
	assign mem_addr_oe         = !released_q;
	assign prog_mem_select_n   = !sel[0];
	assign data_mem_select_n   = !sel[1];
	assign boot_mem_select_n   = !sel[2];
	assign read_strobe_n       = !strobe;
endmodule : ext_bus_grant_and_read
`default_nettype wire

/* tb/ext_bus_chk.sv */
// Checker for the bus grant and read block.
// Sees only the top module's ports; attached by bind.
`include "ext_bus_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ext_bus_chk
(
	input wire logic              clk,
	input wire logic              rst_n,
	input wire logic              ext_bus_request_n,
	input wire logic              bus_grant_out_n,
	input wire logic              rd_req,
	input wire logic              rd_busy,
	input wire logic              rd_done,
	input wire logic [`ADDR_W-1:0] mem_addr_out,
	input wire logic              prog_mem_select_n,
	input wire logic              data_mem_select_n,
	input wire logic              boot_mem_select_n,
	input wire logic              read_strobe_n,
	input wire logic              ctl_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_release; $fell(ctl_oe); endsequence
	sequence s_grant; ##4 $fell(bus_grant_out_n); endsequence
	property p_grant_next; s_release |-> s_grant; endproperty
	a_grant_next: assert property (p_grant_next)
		else $error("grant not one cycle after release");
	property p_off_first;
		$fell(bus_grant_out_n) |-> !ctl_oe && !$past(ctl_oe);
	endproperty
	a_off_first: assert property (p_off_first)
		else $error("grant before release");
	property p_held_off; !bus_grant_out_n |-> !ctl_oe; endproperty
	a_held_off: assert property (p_held_off)
		else $error("driving while granted");
	property p_reenable; $rose(bus_grant_out_n) |-> ctl_oe; endproperty
	a_reenable: assert property (p_reenable)
		else $error("not re-enabled");
	property p_idle_off; !ctl_oe |-> !rd_busy; endproperty
	a_idle_off: assert property (p_idle_off)
		else $error("read while released");
	property p_stable;
		!$past(read_strobe_n) |-> $stable({mem_addr_out,
			prog_mem_select_n, data_mem_select_n, boot_mem_select_n});
	endproperty
	a_stable: assert property (p_stable)
		else $error("address moved under strobe");
	property p_done; rd_done |-> $rose(read_strobe_n); endproperty
	a_done: assert property (p_done)
		else $error("done not at strobe end");
	property p_answer;
		(!ext_bus_request_n && !rd_req && !rd_busy)[*8]
			|-> ##[0:12] !bus_grant_out_n;
	endproperty
	a_answer: assert property (p_answer)
		else $error("request not answered");
endmodule : ext_bus_chk
bind ext_bus_grant_and_read ext_bus_chk chk (.clk, .rst_n,
	.ext_bus_request_n, .bus_grant_out_n, .rd_req, .rd_busy, .rd_done,
	.mem_addr_out, .prog_mem_select_n, .data_mem_select_n,
	.boot_mem_select_n, .read_strobe_n, .ctl_oe);
`default_nettype wire

/* tb/ext_bus_mem_model.sv */
// Memory model: data tagged with select and address.
// Assumes the block's select, strobe and address pins.
`include "ext_bus_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ext_bus_mem_model
(
	input wire logic               clk,
	input wire logic               ctl_oe,
	input wire logic               read_strobe_n,
	input wire logic [`SEL_W-1:0]  sel_n,
	input wire logic [`ADDR_W-1:0] addr,
	output logic [`DATA_W-1:0]     data
);
	// Outside a read the bus toggles so stale data never passes;
	// it starts unknown, so a sample taken before any read shows up
	always_ff @(posedge clk)
		if (ctl_oe && !read_strobe_n && sel_n != 3'h7)
			data <= {~sel_n, 7'h00, addr};
		else
			data <= ~data;
endmodule : ext_bus_mem_model
`default_nettype wire

/* tb/ext_bus_grant_and_read_tb.sv */
// Testbench: reads of every space with wait counts 0, 1, 3, 4, 6 and 7, then bus grants.
// Assumes the memory model and the bound checker.
`include "ext_bus_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ext_bus_grant_and_read_tb;
	import ext_bus_pkg::*;
	logic clk, rst_n, ext_bus_request_n, bus_grant_out_n, rd_req;
	logic rd_busy, rd_done, mem_addr_oe, ctl_oe, processor_clock_out;
	logic prog_mem_select_n, data_mem_select_n, boot_mem_select_n;
	logic read_strobe_n;
	mem_space_t rd_space;
	logic [`ADDR_W-1:0] rd_addr, mem_addr_out;
	logic [`WAIT_W-1:0] rd_waits;
	logic [`DATA_W-1:0] rd_data, mem_data_in;
	int errors, n_tests;
	ext_bus_grant_and_read uut (.clk, .rst_n, .ext_bus_request_n,
		.bus_grant_out_n, .processor_clock_out, .rd_req, .rd_space,
		.rd_addr, .rd_waits, .rd_busy, .rd_done, .rd_data, .mem_data_in,
		.mem_addr_out, .mem_addr_oe, .prog_mem_select_n,
		.data_mem_select_n, .boot_mem_select_n, .read_strobe_n, .ctl_oe);
	ext_bus_mem_model mem (.clk, .ctl_oe, .read_strobe_n,
		.sel_n({boot_mem_select_n, data_mem_select_n, prog_mem_select_n}),
		.addr(mem_addr_out), .data(mem_data_in));
	task automatic give_verdict;
		if (errors == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	task automatic check(input logic ok, input string msg);
		n_tests++;
		if (ok !== 1'b1)
		begin
			errors++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask : check
	task automatic check_clock_out;
		int i, highs, edges;
		logic prev;
		highs = 0;
		edges = 0;
		@(posedge clk);
		#1;
		prev = processor_clock_out;
		for (i = 0; i < 2 * `PROC_CYCLE_CLKS; i++)
		begin
			@(posedge clk);
			#1;
			if (processor_clock_out === 1'b1)
				highs++;
			if (processor_clock_out !== prev)
				edges++;
			prev = processor_clock_out;
		end
		check(highs == `PROC_CYCLE_CLKS, "clock-out duty");
		check(edges == 4, "clock-out period");
	endtask : check_clock_out
	task automatic do_read(input mem_space_t sp, input logic [13:0] a,
		input logic [2:0] w);
		int i, low;
		logic [2:0] sel;
		logic done;
		sel = 3'h1 << sp;
		low = 0;
		done = 1'b0;
		@(posedge clk);
		rd_space <= sp;
		rd_addr <= a;
		rd_waits <= w;
		rd_req <= 1'b1;
		for (i = 0; i < 300 && !done; i++)
		begin
			@(posedge clk);
			#1;
			if (read_strobe_n === 1'b0)
				low++;
			done = rd_done === 1'b1;
		end
		check(done, "read timeout");
		if (!done)
			give_verdict();
		check(low == 4 * (w + 1), "strobe width");
		check(rd_data === {sel, 7'h00, a}, "read data");
		// Drop the request on an edge, never in the step the next call raises it
		@(posedge clk);
		rd_req <= 1'b0;
	endtask : do_read
	task automatic wait_grant(input logic lvl);
		int i;
		for (i = 0; i < 40 && bus_grant_out_n !== lvl; i++)
		begin
			@(posedge clk);
			#1;
		end
		check(i < 40, "grant timeout");
		if (i >= 40)
			give_verdict();
	endtask : wait_grant
	// Request moves off the clock grid: the pin is asynchronous
	task automatic do_grant(input int dly);
		@(posedge clk);
		ext_bus_request_n <= #(dly) 1'b0;
		wait_grant(1'b0);
		check(ctl_oe === 1'b0, "still driving");
		check(mem_addr_oe === 1'b0, "address still driven");
		@(posedge clk);
		rd_req <= 1'b1;
		repeat (12) @(posedge clk);
		#1;
		check(rd_busy === 1'b0, "read while granted");
		@(posedge clk);
		ext_bus_request_n <= 1'b1;
		wait_grant(1'b1);
		check(ctl_oe === 1'b1, "not re-enabled");
		check(mem_addr_oe === 1'b1, "address not re-enabled");
		do_read(rd_space, rd_addr, rd_waits);
	endtask : do_grant
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial
	begin
		rst_n = 1'b0;
		ext_bus_request_n = 1'b1;
		rd_req = 1'b0;
		rd_space = MEM_PROG;
		rd_addr = 14'h0000;
		rd_waits = 3'h0;
		errors = 0;
		n_tests = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		check_clock_out();
		for (int k = 0; k < 6; k++)
			do_read(mem_space_t'(k % 3), 14'h3a5c ^ k[13:0],
				3'((k * 3) % 8));
		do_grant(3);
		do_grant(37);
		give_verdict();
	end
endmodule : ext_bus_grant_and_read_tb
`default_nettype wire
